// file: logic/pio_cell.sv
// Pad input capture and output cell with APB configuration
`timescale 1ns/1ps
module pio_cell
   import pio_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pad_in,
   output logic             pad_out,
   output logic             pad_oe,
   input  wire logic        out_clk_pin,
   input  wire logic        in_clk_pin,
   input  wire logic        global_init_pulse,
   input  wire logic        fab_out_d,
   input  wire logic        fab_float,
   input  wire logic        fab_ce,
   output logic             fab_in_q
);
   // Whole state of the cell, apart from the pin synchroniser flops, in one record
   typedef struct packed {
      logic [PIO_CFG_W-1:0] cfg;
      logic                 sw_init;
      logic                 oclk_prev;
      logic                 iclk_prev;
      logic                 early_q;
      logic                 in_q;
      logic                 out_q;
      logic                 pad_out;
      logic                 pad_oe;
      logic [31:0]          rdata;
   } pio_state_t;

   pio_state_t st_q;
   pio_state_t st_d;

   // Pins from the board cross into pclk through two flops
   pio_sync_if #(.W(PIO_SYN_W)) syn ();

   assign syn.raw[PIO_SYN_PAD]  = pad_in;
   assign syn.raw[PIO_SYN_OCLK] = out_clk_pin;
   assign syn.raw[PIO_SYN_ICLK] = in_clk_pin;
   assign syn.raw[PIO_SYN_INIT] = global_init_pulse;

   pio_sync #(
      .W       (PIO_SYN_W)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (syn)
   );

   // Decoded bus phases
   logic setup_rd;
   logic access_wr;
   logic addr_hit;

   assign addr_hit  = (paddr == PIO_CFG_OFS) || (paddr == PIO_CTRL_OFS)
                    || (paddr == PIO_STATUS_OFS);
   assign setup_rd  = psel && !penable && !pwrite;
   assign access_wr = psel && penable && pwrite && addr_hit;

   // Zero wait states; unmapped addresses flag an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // Working values of the cell, derived from the record
   logic pad_s;
   logic oclk;
   logic iclk;
   logic oclk_rise;
   logic iclk_rise;
   logic init_now;
   logic init_val;
   logic in_src;
   logic float_eff;
   logic ce_eff;
   logic out_val;
   logic [31:0] status;

   always_comb begin
      // Clock polarity absorbed into the cell
      pad_s     = syn.sync[PIO_SYN_PAD];
      oclk      = syn.sync[PIO_SYN_OCLK] ^ st_q.cfg[PIO_CFG_INV_OCLK]; // R4
      iclk      = syn.sync[PIO_SYN_ICLK] ^ st_q.cfg[PIO_CFG_INV_ICLK]; // R4
      oclk_rise = oclk && !st_q.oclk_prev;
      iclk_rise = iclk && !st_q.iclk_prev;
      // Pin or software request, both reach every storage element
      init_now  = syn.sync[PIO_SYN_INIT] || st_q.sw_init; // R13
      init_val  = st_q.cfg[PIO_CFG_INIT_SET]; // R10
      // Unused controls fall back to their idle sense
      float_eff = st_q.cfg[PIO_CFG_FLOAT_CONN] ? fab_float : 1'b0; // R11
      ce_eff    = st_q.cfg[PIO_CFG_CE_CONN] ? fab_ce : 1'b1; // R12
      float_eff = float_eff ^ st_q.cfg[PIO_CFG_FLOAT_INV]; // R8
      out_val   = fab_out_d ^ st_q.cfg[PIO_CFG_OUT_INV]; // R6 R8
      // Input stage source
      in_src    = st_q.cfg[PIO_CFG_EARLY_EN] ? st_q.early_q : pad_s; // R14
      status                 = 32'h0000_0000;
      status[PIO_ST_PAD]     = pad_s;
      status[PIO_ST_EARLY]   = st_q.early_q;
      status[PIO_ST_INQ]     = st_q.in_q;
      status[PIO_ST_OUTQ]    = st_q.out_q;
      status[PIO_ST_OE]      = st_q.pad_oe;
   end

   // Next state of the whole cell
   always_comb begin
      st_d           = st_q;
      st_d.oclk_prev = oclk;
      st_d.iclk_prev = iclk;
      st_d.sw_init   = 1'b0;

      // Register writes land in the access phase
      if (access_wr && paddr == PIO_CFG_OFS) begin
         st_d.cfg = pwdata[PIO_CFG_W-1:0];
      end
      if (access_wr && paddr == PIO_CTRL_OFS) begin
         st_d.sw_init = pwdata[PIO_CTRL_INIT];
      end

      // Read data captured in setup so it is steady in access
      if (setup_rd) begin
         case (paddr)
            PIO_CFG_OFS:    st_d.rdata = {{(32-PIO_CFG_W){1'b0}}, st_q.cfg};
            PIO_CTRL_OFS:   st_d.rdata = 32'h0000_0000;
            PIO_STATUS_OFS: st_d.rdata = status;
            default:        st_d.rdata = 32'h0000_0000;
         endcase
      end

      if (init_now) begin
         // Storage forced while the init request stands
         st_d.early_q = init_val; // R13
         st_d.in_q    = init_val; // R13
         st_d.out_q   = init_val; // R10 R13
      end else begin
         // Early latch follows the pad while the output clock is low
         if (!oclk) begin
            st_d.early_q = pad_s; // R1 R2 R3
         end
         if (st_q.cfg[PIO_CFG_LATCH_VAR]) begin
            // Second stage is a latch, open while its clock is high
            if (iclk) begin
               st_d.in_q = in_src; // R3
            end
         end else if (iclk_rise) begin
            st_d.in_q = in_src; // R2
         end
         // Output register shares the output clock with the early latch
         if (oclk_rise && ce_eff) begin
            st_d.out_q = out_val; // R9
         end
      end

      // Pad drive: direct or registered value, float overrides all
      st_d.pad_out = st_q.cfg[PIO_CFG_OUT_REG] ? st_q.out_q : out_val; // R6
      st_d.pad_oe  = !float_eff; // R7
   end

   // Single register stage for the entire record
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q         <= '0;
         st_q.cfg     <= PIO_CFG_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata   = st_q.rdata;
   assign pad_out  = st_q.pad_out;
   assign pad_oe   = st_q.pad_oe;
   assign fab_in_q = st_q.in_q;
endmodule // pio_cell

// file: include/pio_pkg.sv
// Package of constants for the pad capture and output cell
// Contract
// (R1) Early latch runs on the output clock
// (R2) Flop variant: low-transparent latch, rising flop
// (R3) Latch variant: low latch feeds high latch
// (R4) Each input storage clock may be inverted
// (R5) Integrator drives early and low-skew clocks
// (R6) Output inverts, then direct or registered
// (R7) Float high releases the pad driver
// (R8) Output and float polarity set per cell
// (R9) Output register loads on edge with enable
// (R10) Init value set or reset, reset default
// (R11) Unused float input reads as low
// (R12) Unused clock enable reads as high
// (R13) Global init forces all storage elements
// (R14) Without early latch, input takes pad directly
package pio_pkg;
   // Register byte offsets
   localparam logic [11:0] PIO_CFG_OFS    = 12'h000;
   localparam logic [11:0] PIO_CTRL_OFS   = 12'h004;
   localparam logic [11:0] PIO_STATUS_OFS = 12'h008;
   // Configuration field positions
   localparam int PIO_CFG_EARLY_EN   = 0;
   localparam int PIO_CFG_LATCH_VAR  = 1;
   localparam int PIO_CFG_INV_OCLK   = 2;
   localparam int PIO_CFG_INV_ICLK   = 3;
   localparam int PIO_CFG_OUT_INV    = 4;
   localparam int PIO_CFG_OUT_REG    = 5;
   localparam int PIO_CFG_FLOAT_INV  = 6;
   localparam int PIO_CFG_INIT_SET   = 7;
   localparam int PIO_CFG_FLOAT_CONN = 8;
   localparam int PIO_CFG_CE_CONN    = 9;
   localparam int PIO_CFG_W          = 10;
   localparam logic [PIO_CFG_W-1:0] PIO_CFG_RST = 10'h000;
   // Control field: self-clearing software init pulse
   localparam int PIO_CTRL_INIT = 0;
   // Status field positions
   localparam int PIO_ST_PAD   = 0;
   localparam int PIO_ST_EARLY = 1;
   localparam int PIO_ST_INQ   = 2;
   localparam int PIO_ST_OUTQ  = 3;
   localparam int PIO_ST_OE    = 4;
   // Synchronised pin positions
   localparam int PIO_SYN_PAD  = 0;
   localparam int PIO_SYN_OCLK = 1;
   localparam int PIO_SYN_ICLK = 2;
   localparam int PIO_SYN_INIT = 3;
   localparam int PIO_SYN_W    = 4;
endpackage

// file: include/pio_sync_if.sv
// Interface carrying raw pins into the synchroniser and levels back out
`timescale 1ns/1ps
interface pio_sync_if #(parameter int W = 4);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport sync_side (input raw, output sync);
   modport user      (output raw, input sync);
endinterface

// file: logic/pio_sync.sv
// Two-flop synchroniser bank for pins entering the pclk domain
`timescale 1ns/1ps
module pio_sync
   import pio_pkg::*;
#(
   parameter int W = PIO_SYN_W
) (
   input  wire logic     pclk,
   input  wire logic     presetn,
   pio_sync_if.sync_side sif
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } pio_sync_st_t;

   pio_sync_st_t s_q;
   pio_sync_st_t s_d;

   // First stage is read only by the second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = sif.raw;
      s_d.stab = s_q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sif.sync = s_q.stab;
endmodule // pio_sync

// file: test/pio_cell_monitor.sv
// Port checker for the pad capture and output cell
`timescale 1ns/1ps
module pio_cell_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pad_in,
   input wire logic        pad_out,
   input wire logic        pad_oe,
   input wire logic        in_clk_pin,
   input wire logic        global_init_pulse,
   input wire logic        fab_out_d,
   input wire logic        fab_float,
   input wire logic        fab_ce,
   input wire logic        fab_in_q
);
   logic [9:0] cfg_q;
   // Shadow of the config word, so checks need no design internals
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) cfg_q <= 10'h000;
      else if (psel && penable && pwrite && pready && paddr == 12'h000) cfg_q <= pwdata[9:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err; psel && penable && paddr > 12'h008 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access without error");
   property p_cfg; psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {22'h0, cfg_q};
   endproperty
   a_cfg: assert property (p_cfg) else $error("config readback differs");
   property p_flt; cfg_q[8] && !cfg_q[6] && fab_float |=> !pad_oe; endproperty
   a_flt: assert property (p_flt) else $error("float ignored");
   property p_drv; !cfg_q[8] && !cfg_q[6] |=> pad_oe; endproperty
   a_drv: assert property (p_drv) else $error("unused float not driven");
   property p_dir; !cfg_q[5] |=> pad_out == ($past(fab_out_d) ^ $past(cfg_q[4])); endproperty
   a_dir: assert property (p_dir) else $error("direct output wrong");
   property p_hld;
      (cfg_q[5] && cfg_q[9] && !fab_ce && !global_init_pulse)[*6] |=> $stable(pad_out);
   endproperty
   a_hld: assert property (p_hld) else $error("register moved without enable");
   property p_ini;
      global_init_pulse[*4] |=> fab_in_q == cfg_q[7] && (!cfg_q[5] || pad_out == cfg_q[7]);
   endproperty
   a_ini: assert property (p_ini) else $error("init value not forced");
   property p_flp; cfg_q[3:0] == 4'h0 && $rose(in_clk_pin) |-> ##[2:5] fab_in_q == pad_in;
   endproperty
   a_flp: assert property (p_flp) else $error("flop stage missed pad");
   property p_lat;
      (cfg_q[3:0] == 4'h2 && in_clk_pin && $stable(pad_in))[*5] |=> fab_in_q == pad_in;
   endproperty
   a_lat: assert property (p_lat) else $error("latch stage not transparent");
   c_flt: cover property (cfg_q[8] && fab_float);
   c_ini: cover property (global_init_pulse);
   c_err: cover property (pslverr);
endmodule // pio_cell_monitor

// file: test/pio_board.sv
// Board side: one clock pad feeding both clocks, plus the pad level
`timescale 1ns/1ps
module pio_board (
   input  wire logic pclk,
   input  wire logic run,
   input  wire logic idle,
   input  wire logic lvl,
   output logic      pad_in,
   output logic      out_clk_pin,
   output logic      in_clk_pin
);
   logic [2:0] div_q = 3'h0;
   initial pad_in = 1'b0;
   // While run is high, pad moves only at start of low phase, far from the rising edge
   // Plain always: the pad level also has a start value of its own
   always @(posedge pclk) begin
      div_q <= run ? div_q + 3'h1 : 3'h0;
      if (!run || div_q == 3'h7) pad_in <= lvl;
   end
   // Same source for both clocks; follows idle outside frames
   assign out_clk_pin = run ? div_q[2] : idle;
   assign in_clk_pin  = run ? div_q[2] : idle;
endmodule // pio_board

// file: test/pio_cell_test.sv
// Self-checking bench for the pad capture and output cell
`timescale 1ns/1ps
module pio_cell_test;
   import pio_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        pad_in, pad_out, pad_oe, out_clk_pin, in_clk_pin, global_init_pulse;
   logic        fab_out_d, fab_float, fab_ce, fab_in_q, run, idle, lvl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          error_cnt = 0;
   int          checked = 0;
   pio_cell pio_cell_inst (.*);
   pio_board pio_board_inst (.pclk(pclk), .run(run), .idle(idle), .lvl(lvl), .pad_in(pad_in),
      .out_clk_pin(out_clk_pin), .in_clk_pin(in_clk_pin));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // One bus transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         error_cnt++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_bus();
      apb(1'b1, 12'h000, 32'h3ff);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h3ff);
      apb(1'b0, 12'h00c, 32'h0);
      chk(er, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_out();
      apb(1'b1, 12'h000, 32'h010);
      fab_out_d <= 1'b1;
      tick(3);
      chk(pad_out, 1'b0);
      chk(pad_oe, 1'b1);
      apb(1'b1, 12'h000, 32'h140);
      tick(3);
      chk(pad_oe, 1'b0);
      fab_float <= 1'b1;
      apb(1'b1, 12'h000, 32'h100);
      tick(3);
      chk(pad_oe, 1'b0);
      fab_float <= 1'b0;
      tick(3);
      chk(pad_oe, 1'b1);
   endtask
   // Registered output: enable, unused enable, then init set
   task automatic t_reg();
      apb(1'b1, 12'h000, 32'h220);
      run <= 1'b1;
      tick(40);
      chk(pad_out, 1'b0);
      fab_ce <= 1'b1;
      tick(20);
      chk(pad_out, 1'b1);
      fab_ce <= 1'b0;
      fab_out_d <= 1'b0;
      apb(1'b1, 12'h000, 32'h020);
      tick(20);
      chk(pad_out, 1'b0);
      run <= 1'b0;
      apb(1'b1, 12'h000, 32'h0a0);
      global_init_pulse <= 1'b1;
      tick(6);
      chk(pad_out, 1'b1);
      chk(fab_in_q, 1'b1);
      global_init_pulse <= 1'b0;
      // Software init pulse with reset value, no clock edges around
      apb(1'b1, 12'h000, 32'h020);
      apb(1'b1, 12'h004, 32'h001);
      tick(3);
      chk(pad_out, 1'b0);
      chk(fab_in_q, 1'b0);
   endtask
   task automatic t_in();
      apb(1'b1, 12'h000, 32'h000);
      run <= 1'b1;
      tick(40);
      chk(fab_in_q, 1'b0);
      lvl <= 1'b1;
      tick(20);
      chk(fab_in_q, 1'b1);
      apb(1'b1, 12'h000, 32'h008);
      lvl <= 1'b0;
      tick(24);
      chk(fab_in_q, 1'b0);
      run <= 1'b0;
      idle <= 1'b1;
      apb(1'b1, 12'h000, 32'h001);
      lvl <= 1'b1;
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[PIO_ST_EARLY], 1'b0);
      idle <= 1'b0;
      tick(8);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[PIO_ST_EARLY], 1'b1);
      idle <= 1'b1;
      lvl <= 1'b0;
      apb(1'b1, 12'h000, 32'h002);
      tick(8);
      chk(fab_in_q, 1'b0);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, global_init_pulse} = 5'h00;
      {fab_out_d, fab_float, fab_ce, run, idle, lvl} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_bus();
      t_out();
      t_reg();
      t_in();
      test_done();
   end
endmodule // pio_cell_test
bind pio_cell pio_cell_monitor pio_cell_monitor_inst (.*);
